// >>> rtl/asc_params.svh
// Constants for the angle signal-conditioning block
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define ASC_A_PROG 9'h000
`define ASC_A_PH 9'h004
`define ASC_A_GX 9'h008
`define ASC_A_GY 9'h00C
`define ASC_A_OX 9'h010
`define ASC_A_OY 9'h014
`define ASC_A_ZR 9'h018
`define ASC_A_SL 9'h01C
`define ASC_A_OO 9'h020
`define ASC_A_CL 9'h024
`define ASC_A_CH 9'h028
`define ASC_A_ML 9'h02C
`define ASC_A_MH 9'h030
`define ASC_A_LP 9'h034
`define ASC_A_DB 9'h038
`define ASC_A_PR 9'h03C
`define ASC_A_FLAGS 9'h040
`define ASC_SP_LAST 6'd32

// -----------------------------------------------------------------
// Status bits, reset values, arithmetic scaling
// -----------------------------------------------------------------
`define ASC_BIT_PUMP 10
`define ASC_BIT_SUPPLY 9
`define ASC_BIT_NVRAM 8
`define ASC_GAIN_RST 16'h4000
`define ASC_SLOPE_RST 16'h0200
`define ASC_GAIN_SHIFT 14
`define ASC_PH_SHIFT 15
`define ASC_SLOPE_SHIFT 9
`define ASC_OFS_SHIFT 1
`define ASC_SEG_SHIFT 10
`define ASC_LP_SHIFT 16
`define ASC_MAG_SHIFT 8
`define ASC_S16_MAX 36'sh0_0000_7FFF
`define ASC_S16_MIN -36'sh0_0000_8000
`define ASC_FULL 15'h7FFF
`define ASC_CLL_BASE 9'h100
`define ASC_CLH_DIV 32'd127

// -----------------------------------------------------------------
// PWM timing
// -----------------------------------------------------------------
`define ASC_CLK_HZ 125000000
`define ASC_PWM_HZ0 2000
`define ASC_PWM_HZ1 1000
`define ASC_PWM_HZ2 500
`define ASC_PWM_HZ3 250
`define ASC_STEPS11 2048
`define ASC_STEPS12 4096
`define ASC_TOP11 12'h7FF
`define ASC_TOP12 12'hFFF

`endif

// >>> rtl/asc_pkg.sv
// Types shared by the angle signal-conditioning block
package asc_pkg;

	// Whole state of the conditioning block
	typedef struct packed {
		logic [10:0] prog;
		logic signed [15:0] ph;
		logic signed [15:0] gx;
		logic signed [15:0] gy;
		logic signed [15:0] ox;
		logic signed [15:0] oy;
		logic [15:0] zr;
		logic signed [15:0] sl;
		logic signed [15:0] oo;
		logic [7:0] cl;
		logic [7:0] ch;
		logic [7:0] ml;
		logic [7:0] mh;
		logic [15:0] lp;
		logic [15:0] db;
		logic [1:0] pr;
		logic [32:0][15:0] sp;
		logic signed [15:0] xc;
		logic signed [15:0] yc;
		logic cv;
		logic [14:0] held;
		logic [14:0] y1;
		logic v1;
		logic flo;
		logic fhi;
		logic [14:0] filt;
		logic [14:0] out;
		logic ov;
		logic [6:0] div;
		logic [11:0] cnt;
		logic [11:0] duty;
		logic pwm;
		logic [31:0] rd;
	} asc_state_s;

endpackage

// >>> rtl/asc_top.sv
// Angle signal conditioning: X/Y correction, output shaping, PWM
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "asc_params.svh"
module asc_top import asc_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [8:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// Raw channel samples
	input wire logic signed [15:0] x_raw,
	input wire logic signed [15:0] y_raw,
	input wire logic raw_valid,
	// Corrected channels toward the angle computation
	output logic signed [15:0] x_corr,
	output logic signed [15:0] y_corr,
	output logic corr_valid,
	// Angle and field magnitude from the angle computation
	input wire logic [15:0] angle_in,
	input wire logic [15:0] field_magnitude,
	input wire logic angle_valid,
	// Memory programming events
	input wire logic pump_low,
	input wire logic supply_low,
	input wire logic nvram_fail,
	// Conditioned output
	output logic [14:0] out_code,
	output logic out_valid,
	output logic field_low,
	output logic field_high,
	output logic pwm_out
);

	// -----------------------------------------------------------------
	// Helper functions
	// -----------------------------------------------------------------

	// Signed saturation to 16 bits
	function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
		if (v > `ASC_S16_MAX)
			return 16'sh7FFF;
		if (v < `ASC_S16_MIN)
			return -16'sh8000;
		return v[15:0];
	endfunction

	// Saturation to the unsigned 15-bit output range
	function automatic logic [14:0] sat15u(input logic signed [35:0] v);
		if (v < 36'sh0)
			return 15'h0;
		if (v > 36'(`ASC_FULL))
			return `ASC_FULL;
		return v[14:0];
	endfunction

	// Lower bound: (256 - code) * 256, code 0 means no lower bound
	function automatic logic [14:0] lo_bound(input logic [7:0] c);
		logic [16:0] v;
		v = {1'b0, 8'(`ASC_CLL_BASE - {1'b0, c}), 8'h0};
		if (c == 8'h0)
			return 15'h0;
		if (v > 17'(`ASC_FULL))
			return `ASC_FULL;
		return v[14:0];
	endfunction

	// Upper bound: full scale less code/127 of it
	function automatic logic [14:0] hi_bound(input logic [7:0] c);
		logic [31:0] v;
		v = (32'(c) * 32'(`ASC_FULL)) / `ASC_CLH_DIV;
		if (32'(c) > `ASC_CLH_DIV)
			return 15'h0;
		return `ASC_FULL - v[14:0];
	endfunction

	// Clock cycles per PWM step, less one
	function automatic logic [6:0] pwm_div(input logic [1:0] r);
		case (r)
			2'd0: return 7'(`ASC_CLK_HZ / (`ASC_PWM_HZ0 * `ASC_STEPS11) - 1);
			2'd1: return 7'(`ASC_CLK_HZ / (`ASC_PWM_HZ1 * `ASC_STEPS12) - 1);
			2'd2: return 7'(`ASC_CLK_HZ / (`ASC_PWM_HZ2 * `ASC_STEPS12) - 1);
			default: return 7'(`ASC_CLK_HZ / (`ASC_PWM_HZ3 * `ASC_STEPS12) - 1);
		endcase
	endfunction

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------

	localparam asc_state_s ASC_RST = '{gx: `ASC_GAIN_RST, gy: `ASC_GAIN_RST,
		sl: `ASC_SLOPE_RST, default: '0};

	asc_state_s s;
	asc_state_s n;

	logic sp_hit;
	assign sp_hit = addr[8] && (addr[7:2] <= `ASC_SP_LAST);

	// Next-state logic
	always_comb begin
		logic signed [15:0] xo;
		logic signed [15:0] yo;
		logic signed [15:0] yp;
		logic [14:0] db;
		logic [14:0] dif;
		logic [14:0] dmag;
		logic [14:0] a;
		logic [8:0] am;
		logic signed [17:0] th;
		logic [4:0] seg;
		logic signed [17:0] spa;
		logic signed [17:0] spb;
		logic signed [17:0] fr;
		logic [14:0] lin;
		logic [14:0] fo;
		logic [14:0] lo;
		logic [14:0] hi;
		logic [11:0] top;
		xo = '0;
		yo = '0;
		yp = '0;
		db = '0;
		dif = '0;
		dmag = '0;
		a = '0;
		am = '0;
		th = '0;
		seg = '0;
		spa = '0;
		spb = '0;
		fr = '0;
		lin = '0;
		fo = '0;
		lo = '0;
		hi = '0;
		top = '0;
		n = s;
		n.cv = 1'b0;
		n.v1 = 1'b0;
		n.ov = 1'b0;
		n.rd = '0;

		// Register writes; status error bits clear on writing one
		if (wr_en) begin
			case (addr)
				`ASC_A_PROG: begin
					n.prog[7:0] = wr_data[7:0];
					n.prog[10:8] = s.prog[10:8] & ~wr_data[10:8];
				end
				`ASC_A_PH: n.ph = wr_data[15:0];
				`ASC_A_GX: n.gx = wr_data[15:0];
				`ASC_A_GY: n.gy = wr_data[15:0];
				`ASC_A_OX: n.ox = wr_data[15:0];
				`ASC_A_OY: n.oy = wr_data[15:0];
				`ASC_A_ZR: n.zr = wr_data[15:0];
				`ASC_A_SL: n.sl = wr_data[15:0];
				`ASC_A_OO: n.oo = wr_data[15:0];
				`ASC_A_CL: n.cl = wr_data[7:0];
				`ASC_A_CH: n.ch = wr_data[7:0];
				`ASC_A_ML: n.ml = wr_data[7:0];
				`ASC_A_MH: n.mh = wr_data[7:0];
				`ASC_A_LP: n.lp = wr_data[15:0];
				`ASC_A_DB: n.db = wr_data[15:0];
				`ASC_A_PR: n.pr = wr_data[1:0];
				default: ;
			endcase
			if (sp_hit)
				n.sp[addr[7:2]] = wr_data[15:0];
		end

		// Error events applied after the clear so a set wins
		n.prog[`ASC_BIT_PUMP] = n.prog[`ASC_BIT_PUMP] | pump_low;
		n.prog[`ASC_BIT_SUPPLY] = n.prog[`ASC_BIT_SUPPLY] | supply_low;
		n.prog[`ASC_BIT_NVRAM] = n.prog[`ASC_BIT_NVRAM] | nvram_fail;

		// Register reads, data valid in the following cycle only
		if (rd_en) begin
			case (addr)
				`ASC_A_PROG: n.rd = {21'h0, s.prog};
				`ASC_A_PH: n.rd = {16'h0, s.ph};
				`ASC_A_GX: n.rd = {16'h0, s.gx};
				`ASC_A_GY: n.rd = {16'h0, s.gy};
				`ASC_A_OX: n.rd = {16'h0, s.ox};
				`ASC_A_OY: n.rd = {16'h0, s.oy};
				`ASC_A_ZR: n.rd = {16'h0, s.zr};
				`ASC_A_SL: n.rd = {16'h0, s.sl};
				`ASC_A_OO: n.rd = {16'h0, s.oo};
				`ASC_A_CL: n.rd = {24'h0, s.cl};
				`ASC_A_CH: n.rd = {24'h0, s.ch};
				`ASC_A_ML: n.rd = {24'h0, s.ml};
				`ASC_A_MH: n.rd = {24'h0, s.mh};
				`ASC_A_LP: n.rd = {16'h0, s.lp};
				`ASC_A_DB: n.rd = {16'h0, s.db};
				`ASC_A_PR: n.rd = {30'h0, s.pr};
				`ASC_A_FLAGS: n.rd = {30'h0, s.fhi, s.flo};
				default: n.rd = '0;
			endcase
			if (sp_hit)
				n.rd = {16'h0, s.sp[addr[7:2]]};
		end

		// Offset, phase and gain correction; gain 0x4000 is unity
		if (raw_valid) begin
			xo = sat16(36'(x_raw) + 36'(s.ox));
			yo = sat16(36'(y_raw) + 36'(s.oy));
			n.xc = sat16((36'(xo) * 36'(s.gx)) >>> `ASC_GAIN_SHIFT);
			yp = sat16(36'(yo) - ((36'(xo) * 36'(s.ph)) >>> `ASC_PH_SHIFT));
			n.yc = sat16((36'(yp) * 36'(s.gy)) >>> `ASC_GAIN_SHIFT);
			n.cv = 1'b1;
		end

		// Stage one: hysteresis, zero shift, slope and offset, field check
		if (angle_valid) begin
			db = 15'((16'h0 - s.db) >> 1);
			dif = angle_in[14:0] - s.held;
			dmag = dif[14] ? 15'(15'h0 - dif) : dif;
			// Circular distance, so a wrap through zero is a small move
			if (dmag >= db)
				n.held = angle_in[14:0];
			a = n.held + s.zr[15:1];
			n.y1 = sat15u(((36'($signed({1'b0, a})) * 36'(s.sl)) >>> `ASC_SLOPE_SHIFT)
				+ (36'(s.oo) <<< `ASC_OFS_SHIFT));
			am = 9'($signed(s.ml));
			if (am[8])
				am = 9'h0 - am;
			n.flo = {1'b0, field_magnitude} < {am, 8'h0};
			th = 18'($signed({3'b0, `ASC_FULL})) - (18'($signed(s.mh)) <<< `ASC_MAG_SHIFT);
			n.fhi = $signed({2'b0, field_magnitude}) > th;
			n.v1 = 1'b1;
		end

		// Stage two: linearize, filter, clamp
		if (s.v1) begin
			seg = s.y1[14:10];
			spa = $signed({2'b0, s.sp[seg]});
			spb = $signed({2'b0, s.sp[6'(seg) + 6'd1]});
			fr = $signed({8'h0, s.y1[9:0]});
			lin = sat15u(36'(spa) + (((36'(spb) - 36'(spa)) * 36'(fr)) >>> `ASC_SEG_SHIFT));
			// Larger codes give a lower corner; zero bypasses the filter
			if (s.lp == 16'h0)
				fo = lin;
			else
				fo = sat15u(36'($signed({1'b0, s.filt})) + (((36'($signed({1'b0, lin}))
					- 36'($signed({1'b0, s.filt}))) * 36'($signed({1'b0, ~s.lp}))) >>> `ASC_LP_SHIFT));
			n.filt = fo;
			lo = lo_bound(s.cl);
			hi = hi_bound(s.ch);
			// Upper limit checked first; if limits cross it wins only for codes above it
			if (s.flo || s.fhi)
				n.out = hi;
			else if (fo > hi)
				n.out = hi;
			else if (fo < lo)
				n.out = lo;
			else
				n.out = fo;
			n.ov = 1'b1;
		end

		// PWM: step divider, period counter, duty latched per period
		top = (s.pr == 2'd0) ? `ASC_TOP11 : `ASC_TOP12;
		if (s.div == 7'd0) begin
			n.div = pwm_div(s.pr);
			if (s.cnt >= top) begin
				n.cnt = 12'h0;
				n.duty = (s.pr == 2'd0) ? {1'b0, s.out[14:4]} : s.out[14:3];
			end else begin
				n.cnt = s.cnt + 12'd1;
			end
		end else begin
			n.div = s.div - 7'd1;
		end
		n.pwm = s.cnt < s.duty;
	end

	// State register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			s <= ASC_RST;
		else
			s <= n;
	end

	// Outputs come straight from the state register
	assign rd_data = s.rd;
	assign x_corr = s.xc;
	assign y_corr = s.yc;
	assign corr_valid = s.cv;
	assign out_code = s.out;
	assign out_valid = s.ov;
	assign field_low = s.flo;
	assign field_high = s.fhi;
	assign pwm_out = s.pwm;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Independent threshold models; bounds reuse hi_bound and lo_bound
	int h_lo_thr;
	int h_hi_thr;
	logic [14:0] h_hi;
	logic [14:0] h_lo;
	logic h_bad;
	logic h_low_exp;
	logic h_high_exp;
	logic h_err;
	assign h_lo_thr = ($signed(s.ml) < 0 ? -int'($signed(s.ml)) : int'($signed(s.ml))) * 256;
	assign h_hi_thr = 32767 - int'($signed(s.mh)) * 256;
	assign h_hi = hi_bound(s.ch);
	assign h_lo = lo_bound(s.cl);
	// Expected flags held as plain signals so the checks look one cycle back at a signal
	assign h_low_exp = int'(field_magnitude) < h_lo_thr;
	assign h_high_exp = int'(field_magnitude) > h_hi_thr;
	assign h_err = s.flo || s.fhi;
	assign h_bad = h_low_exp || h_high_exp;

	sequence s_ang;
		angle_valid;
	endsequence

	sequence s_bad_ang;
		angle_valid && h_bad && !wr_en;
	endsequence

	a_pump_err_set: assert property (pump_low |=> s.prog[`ASC_BIT_PUMP])
		else $error("pump error bit not set");
	a_supply_err_set: assert property (supply_low |=> s.prog[`ASC_BIT_SUPPLY])
		else $error("supply error bit not set");
	a_nvram_err_sticky: assert property (s.prog[`ASC_BIT_NVRAM] && !(wr_en && addr == `ASC_A_PROG)
		|=> s.prog[`ASC_BIT_NVRAM] && $stable(s.prog[10:8] & 3'b001))
		else $error("memory error bit lost");
	a_field_low_flag: assert property (angle_valid |=> field_low == $past(h_low_exp))
		else $error("field low flag wrong");
	a_field_high_flag: assert property (angle_valid |=> field_high == $past(h_high_exp))
		else $error("field high flag wrong");
	a_field_err_clamp: assert property (s_bad_ang |-> ##2 (out_valid && out_code == $past(h_hi)))
		else $error("field error did not force high clamp");
	a_out_ceiling: assert property (out_valid |-> out_code <= $past(h_hi))
		else $error("output above upper clamp");
	a_out_floor: assert property (out_valid && !$past(h_err) && $past(h_lo) <= $past(h_hi)
		|-> out_code >= $past(h_lo))
		else $error("output below lower clamp");
	a_neutral_path: assert property (raw_valid && s.gx == `ASC_GAIN_RST && s.ox == 16'sh0
		|=> corr_valid && x_corr == $past(x_raw))
		else $error("neutral gain changed the sample");
	a_stage_order: assert property (s_ang |-> ##2 out_valid)
		else $error("output not two cycles after angle");

endmodule

// >>> dv/asc_pwm_meter.sv
// Far-side model: controller that times the high phase of the PWM output
`timescale 1ns/1ps
module asc_pwm_meter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Observed output pin
	input wire logic pwm_out,
	// Measurements handed to the bench
	output logic [31:0] hi_len,
	output logic [31:0] n_pulses
);
	logic [31:0] run_q;

	// -----------------------------------------------------------------
	// High-time meter
	// -----------------------------------------------------------------
	// Counts cycles while high and publishes only on a completed pulse,
	// so a pulse cut by reset never reports a short bogus length
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_q <= 32'h0;
			hi_len <= 32'h0;
			n_pulses <= 32'h0;
		end else if (pwm_out) begin
			run_q <= run_q + 32'h1;
		end else begin
			if (run_q != 32'h0) begin
				hi_len <= run_q;
				n_pulses <= n_pulses + 32'h1;
			end
			run_q <= 32'h0;
		end
	end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the angle signal-conditioning block
`timescale 1ns/1ps
`include "asc_params.svh"
module testbench;
	logic core_clk = 1'h0;
	logic rst_b = 1'h0;
	logic [8:0] addr = 9'h000;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'h0;
	logic rd_en = 1'h0;
	logic [31:0] rd_data;
	logic signed [15:0] x_raw = 16'h0;
	logic signed [15:0] y_raw = 16'h0;
	logic raw_valid = 1'h0;
	logic signed [15:0] x_corr, y_corr;
	logic corr_valid;
	logic [15:0] angle_in = 16'h0;
	logic [15:0] field_magnitude = 16'h0;
	logic angle_valid = 1'h0;
	logic pump_low = 1'h0;
	logic supply_low = 1'h0;
	logic nvram_fail = 1'h0;
	logic [14:0] out_code;
	logic out_valid, field_low, field_high, pwm_out;
	logic [31:0] hi_len, n_pulses, n0;
	int n_fail = 0;
	int cmp_count = 0;
	int tick;

	// -----------------------------------------------------------------
	// Clock, design and far-side model
	// -----------------------------------------------------------------
	always #4 core_clk = ~core_clk;

	asc_top i_asc_top (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .x_raw(x_raw), .y_raw(y_raw), .raw_valid(raw_valid),
		.x_corr(x_corr), .y_corr(y_corr), .corr_valid(corr_valid), .angle_in(angle_in),
		.field_magnitude(field_magnitude), .angle_valid(angle_valid), .pump_low(pump_low),
		.supply_low(supply_low), .nvram_fail(nvram_fail), .out_code(out_code), .out_valid(out_valid),
		.field_low(field_low), .field_high(field_high), .pwm_out(pwm_out));

	asc_pwm_meter i_asc_pwm_meter (.core_clk(core_clk), .rst_b(rst_b), .pwm_out(pwm_out),
		.hi_len(hi_len), .n_pulses(n_pulses));

	// -----------------------------------------------------------------
	// Bus and stream tasks
	// -----------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge core_clk);
		wr_en <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task rd(input logic [8:0] a, input logic [31:0] e, input string nm);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge core_clk);
		rd_en <= 1'h0;
		#1;
		chk(nm, rd_data, e);
	endtask

	task pulse(input logic [2:0] v);
		@(posedge core_clk);
		{pump_low, supply_low, nvram_fail} <= v;
		@(posedge core_clk);
		{pump_low, supply_low, nvram_fail} <= 3'h0;
	endtask

	task raw(input logic [15:0] x, y, ex, ey);
		@(posedge core_clk);
		x_raw <= x;
		y_raw <= y;
		raw_valid <= 1'h1;
		@(posedge core_clk);
		raw_valid <= 1'h0;
		#1;
		chk("corr_valid", {31'h0, corr_valid}, 32'h1);
		chk("x_corr", {16'h0, x_corr}, {16'h0, ex});
		chk("y_corr", {16'h0, y_corr}, {16'h0, ey});
	endtask

	// Flags land on the taking edge, the code one cycle later
	task ang(input logic [15:0] a, m, input logic [14:0] e, input logic fl, fh);
		@(posedge core_clk);
		angle_in <= a;
		field_magnitude <= m;
		angle_valid <= 1'h1;
		@(posedge core_clk);
		angle_valid <= 1'h0;
		#1;
		chk("field_low", {31'h0, field_low}, {31'h0, fl});
		chk("field_high", {31'h0, field_high}, {31'h0, fh});
		@(posedge core_clk);
		#1;
		chk("out_valid", {31'h0, out_valid}, 32'h1);
		chk("out_code", {17'h0, out_code}, {17'h0, e});
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'h1;
		// Register defaults, then an unmapped place
		for (int i = 0; i < 16; i++) begin
			rd(9'(i * 4), (i == 2 || i == 3) ? 32'h4000 : (i == 7) ? 32'h200 : 32'h0, "reset value");
		end
		rd(9'h0FC, 32'h0, "unmapped");
		// Programming events set sticky bits; write-1 clears, reserved reads 0
		pulse(3'h4);
		rd(`ASC_A_PROG, 32'h400, "status pump");
		pulse(3'h2);
		rd(`ASC_A_PROG, 32'h600, "status supply");
		pulse(3'h1);
		rd(`ASC_A_PROG, 32'h700, "status nvram");
		wr(`ASC_A_PROG, 32'hFFFFFFAB);
		rd(`ASC_A_PROG, 32'hAB, "status clear");
		// An event in the same cycle as a write-1 clear must survive it
		pulse(3'h6);
		fork
			wr(`ASC_A_PROG, 32'h7AB);
			pulse(3'h1);
		join
		rd(`ASC_A_PROG, 32'h1AB, "status set wins");
		wr(`ASC_A_PR, 32'hFFFFFFFF);
		rd(`ASC_A_PR, 32'h3, "pwm rate");
		wr(`ASC_A_PR, 32'h0);
		// Channel correction
		raw(16'h03E8, 16'h07D0, 16'h03E8, 16'h07D0);
		wr(`ASC_A_OX, 32'h64);
		raw(16'h03E8, 16'h07D0, 16'h044C, 16'h07D0);
		wr(`ASC_A_OX, 32'h0);
		wr(`ASC_A_PH, 32'h4000);
		wr(`ASC_A_GX, 32'h2000);
		raw(16'h03E8, 16'h07D0, 16'h01F4, 16'h05DC);
		// Phase error of 30 degrees: X gain back to unity, Y gain 1/cos
		wr(`ASC_A_GX, 32'h4000);
		wr(`ASC_A_GY, 32'h49E6);
		raw(16'h03E8, 16'h07D0, 16'h03E8, 16'h06C3);
		// Identity curve: setpoints spaced 1024 apart
		for (int i = 0; i < 33; i++) begin
			wr(9'h100 + 9'(i * 4), 32'(i * 32'h400));
		end
		// PWM at code 0: a one-step duty shows the step length
		ang(16'h0010, 16'h4000, 15'h0010, 1'h0, 1'h0);
		tick = `ASC_CLK_HZ / (`ASC_PWM_HZ0 * `ASC_STEPS11);
		n0 = n_pulses;
		for (int k = 0; k < 70000 && n_pulses == n0; k++) @(posedge core_clk);
		chk("pwm high time", {31'h0, hi_len >= tick && hi_len <= tick + 2}, 32'h1);
		ang(16'h9234, 16'h4000, 15'h1234, 1'h0, 1'h0);
		wr(9'h104, 32'h800);
		ang(16'h0200, 16'h4000, 15'h0400, 1'h0, 1'h0);
		wr(9'h104, 32'h400);
		// Zero shift, slope, offset
		wr(`ASC_A_ZR, 32'hE000);
		ang(16'h1234, 16'h4000, 15'h0234, 1'h0, 1'h0);
		wr(`ASC_A_ZR, 32'h0);
		wr(`ASC_A_SL, 32'h400);
		ang(16'h1000, 16'h4000, 15'h2000, 1'h0, 1'h0);
		wr(`ASC_A_OO, 32'h800);
		ang(16'h1000, 16'h4000, 15'h3000, 1'h0, 1'h0);
		wr(`ASC_A_SL, 32'h200);
		wr(`ASC_A_OO, 32'h8000);
		ang(16'h7000, 16'h4000, 15'h0000, 1'h0, 1'h0);
		wr(`ASC_A_OO, 32'h0);
		// Clamps
		wr(`ASC_A_CH, 32'h40);
		ang(16'h7000, 16'h4000, 15'h3F7F, 1'h0, 1'h0);
		wr(`ASC_A_CH, 32'h0);
		wr(`ASC_A_CL, 32'hC0);
		ang(16'h1000, 16'h4000, 15'h4000, 1'h0, 1'h0);
		wr(`ASC_A_CL, 32'h0);
		// Magnetic range: thresholds on both sides of each limit
		wr(`ASC_A_ML, 32'h1E);
		ang(16'h1000, 16'h1DFF, 15'h7FFF, 1'h1, 1'h0);
		ang(16'h1000, 16'h1E00, 15'h1000, 1'h0, 1'h0);
		wr(`ASC_A_ML, 32'hE2);
		ang(16'h1000, 16'h1DFF, 15'h7FFF, 1'h1, 1'h0);
		wr(`ASC_A_MH, 32'h1E);
		ang(16'h1000, 16'h6200, 15'h7FFF, 1'h0, 1'h1);
		rd(`ASC_A_FLAGS, 32'h2, "flags");
		ang(16'h1000, 16'h61FF, 15'h1000, 1'h0, 1'h0);
		// Hysteresis of 50 codes
		wr(`ASC_A_DB, 32'hFF9C);
		ang(16'h1031, 16'h4000, 15'h1000, 1'h0, 1'h0);
		ang(16'h1032, 16'h4000, 15'h1032, 1'h0, 1'h0);
		wr(`ASC_A_DB, 32'h0);
		ang(16'h1000, 16'h4000, 15'h1000, 1'h0, 1'h0);
		// Low-pass: half the remaining step each sample
		wr(`ASC_A_LP, 32'h8000);
		ang(16'h3000, 16'h4000, 15'h1FFF, 1'h0, 1'h0);
		ang(16'h3000, 16'h4000, 15'h27FF, 1'h0, 1'h0);
		wr(`ASC_A_LP, 32'h0);
		complete_run();
	end

	// -----------------------------------------------------------------
	// Watchdog: one full PWM period plus the register traffic, with margin
	// -----------------------------------------------------------------
	initial begin
		repeat (90000) @(posedge core_clk);
		n_fail++;
		complete_run();
	end
endmodule
